// *** alu_unit_defines.svh ***
// Constants for the add, logic and branch execution unit
`ifndef ALU_UNIT_DEFINES_SVH
`define ALU_UNIT_DEFINES_SVH
// Opfields of the logic unit (7 bits)
`define OPL_ABS32       7'h1A
`define OPL_ABS40       7'h38
`define OPL_ADD_SS_S    7'h03
`define OPL_ADD_SS_L    7'h23
`define OPL_UNSIGNED_SUM_OP_UU_L   7'h2B
`define OPL_ADD_SL_L    7'h21
`define OPL_UNSIGNED_SUM_OP_UL_L   7'h29
`define OPL_ADD_C5_S    7'h02
`define OPL_ADD_C5_L    7'h20
`define OPL_AND_RR      7'h7B
`define OPL_AND_C5      7'h7A
// Opfields of the shift unit (6 bits)
`define OPS_ADD_RR      6'h07
`define OPS_ADD_C5      6'h06
`define OPS_DUAL_HALF_SUM_OP        6'h01
`define OPS_AND_RR      6'h1F
`define OPS_AND_C5      6'h1E
// Opfields of the data-address unit (6 bits)
`define OPD_ADD_RR      6'h10
`define OPD_ADD_C5      6'h12
`define OPD_SUM_BYTE_R  6'h30
`define OPD_SUM_HALF_R  6'h34
`define OPD_SUM_WORD_R  6'h38
`define OPD_SUM_BYTE_C  6'h32
`define OPD_SUM_HALF_C  6'h36
`define OPD_SUM_WORD_C  6'h3A
// Addressing mode register layout
`define AMR_BK0_LSB     16
`define AMR_BK1_LSB     21
`define AMR_MODE_CIRC0  2'h1
`define AMR_MODE_CIRC1  2'h2
// Branch timing
`define BRANCH_DELAY_SLOTS 3'h5
`endif

// *** alu_unit_pkg.sv ***
// Types for the add, logic and branch execution unit
package alu_unit_pkg;
    typedef enum logic [1:0] {UNIT_L, UNIT_S, UNIT_D} unit_sel_e;
    typedef struct packed {
        logic        valid;     // Instruction present in E1
        logic        cond;      // Predicate evaluated true
        unit_sel_e   unit;      // Functional unit
        logic [6:0]  op;        // Opfield (6-bit units use low bits)
        logic        is_immediate16_sum_op;   // 16-bit constant add
        logic        is_branch; // Displacement branch
        logic [4:0]  src1_idx;  // Base register index for address unit
        logic        side_b;    // Register file side B
        logic [4:0]  cst5;      // 5-bit constant field
        logic [15:0] cst16;     // 16-bit constant
        logic [20:0] cst21;     // 21-bit constant
    } instr_s;
    typedef struct packed {
        logic        wr_en;     // Destination write
        logic [39:0] data;      // Result, 40 bits wide
    } result_s;
    typedef enum logic [0:0] {BR_IDLE, BR_SLOTS} branch_state_e;
    typedef struct packed {
        result_s       res;
        logic          pfc_load;
        logic [31:0]   program_fetch_counter;
        branch_state_e br_state;
        logic [2:0]    slot_cnt;
    } state_s;
endpackage

// *** alu_unit.sv ***
// Add, logic and displacement-branch execution in the first execute stage
`include "alu_unit_defines.svh"
module alu_unit
    import alu_unit_pkg::*;
(
    input  wire logic        sys_clk_in,                   // Processor clock
    input  wire logic        rst_in,                       // Async reset, active high
    input  wire instr_s      instr_in,                     // Decoded E1 instruction
    input  wire logic [39:0] src1_in,                      // First source operand
    input  wire logic [39:0] src2_in,                      // Second source operand
    input  wire logic [31:0] dst_old_in,                   // Current destination value
    input  wire logic [31:0] packet_base_address_in,       // Address of packet in E1
    input  wire logic [31:0] addressing_mode_register_in,  // Addressing mode settings
    output logic             dst_wr_out,                   // Destination write strobe
    output logic      [39:0] dst_data_out,                 // Destination result
    output logic             pfc_load_out,                 // Load program_fetch_counter
    output logic      [31:0] program_fetch_counter_out,    // New fetch address
    output logic             int_block_out                 // Interrupts held off
);
    // ==============================================================
    // Helper functions
    // ==============================================================
    // Sign-extend a 5-bit constant to 40 bits
    function automatic logic [39:0] sext5(input logic [4:0] c);
        sext5 = {{35{c[4]}}, c};
    endfunction

    // Zero-extend a 32-bit result to the 40-bit bus
    function automatic logic [39:0] zx(input logic [31:0] v);
        zx = {8'h00, v};
    endfunction

    // Sign-extend a 32-bit operand for the 40-bit forms
    function automatic logic [39:0] sx(input logic [31:0] v);
        sx = {{8{v[31]}}, v};
    endfunction

    // Saturating magnitude of a w-bit value held in 40 bits
    function automatic logic [39:0] sat_abs(input logic [39:0] v, input logic wide);
        logic [39:0] r;
        r = '0;
        if (wide) begin
            if (v == 40'h80_0000_0000) r = 40'h7F_FFFF_FFFF;
            else if (v[39]) r = 40'(-v);
            else r = v;
        end else begin
            if (v[31:0] == 32'h8000_0000) r = 40'h7FFF_FFFF;
            else if (v[31]) r = {8'h00, 32'(-v[31:0])};
            else r = {8'h00, v[31:0]};
        end
        sat_abs = r;
    endfunction

    // ==============================================================
    // State registers
    // ==============================================================
    state_s st;        // Registered state
    state_s next_st;   // Next state

    // Circular-mode helpers
    logic [31:0] offset;     // Scaled offset
    logic        circ;       // Circular mode selected
    logic [4:0]  bk;         // Block size field
    logic [31:0] mask;       // Low-bit mask, bits N..0
    logic [31:0] addr_sum;   // Address result

    // Operand views shared by the opfield decode
    logic [31:0] a32;        // Low word of first source
    logic [31:0] b32;        // Low word of second source
    logic [39:0] k40;        // 5-bit constant, sign-extended
    logic [31:0] k32;        // Same constant, 32-bit form
    logic [31:0] k16;        // 16-bit constant, sign-extended
    logic [31:0] br_disp;    // Branch constant in bytes

    // Shared views keep the opfield lines short; OPD_ADD_C5 zero-extends cst5 in place instead of using k32
    assign a32     = src1_in[31:0];
    assign b32     = src2_in[31:0];
    assign k40     = sext5(instr_in.cst5);
    assign k32     = k40[31:0];
    assign k16     = {{16{instr_in.cst16[15]}}, instr_in.cst16};
    assign br_disp = {{9{instr_in.cst21[20]}}, instr_in.cst21, 2'b00};

    // ==============================================================
    // Address unit scaled/circular sum
    // ==============================================================
    always_comb begin
        offset = instr_in.op[1] ? {27'h0, instr_in.cst5} : src1_in[31:0];
        case (instr_in.op[5:0])
            `OPD_SUM_HALF_R, `OPD_SUM_HALF_C: offset = offset << 1;
            `OPD_SUM_WORD_R, `OPD_SUM_WORD_C: offset = offset << 2;
            default:                          offset = offset;
        endcase
        circ = 1'b0;
        bk   = '0;
        if (instr_in.op[5] && instr_in.src1_idx[4:2] == 3'h1) begin
            case (addressing_mode_register_in[{instr_in.side_b, instr_in.src1_idx[1:0],
                                               1'b0} +: 2])
                `AMR_MODE_CIRC0: begin
                    circ = 1'b1;
                    // Byte block size from field zero
                    bk = addressing_mode_register_in[`AMR_BK0_LSB +: 5];
                end
                `AMR_MODE_CIRC1: begin
                    circ = 1'b1;
                    bk = addressing_mode_register_in[`AMR_BK1_LSB +: 5];
                end
                default: circ = 1'b0;
            endcase
        end
        // Buffer size is 2^(N+1) bytes, N = block field
        mask = (bk == 5'h1F) ? 32'hFFFF_FFFF : ((32'h2 << bk) - 32'h1);
        // Carry blocked, offset modulo, high bits kept
        if (circ) addr_sum = (src2_in[31:0] & ~mask) |
                             ((src2_in[31:0] + (offset & mask)) & mask);
        else addr_sum = src2_in[31:0] + offset;
    end

    // ==============================================================
    // E1 execution and branch slot tracking
    // ==============================================================
    always_comb begin
        next_st = st;
        next_st.res.wr_en = 1'b0;
        next_st.pfc_load  = 1'b0;
        // False predicate: no write, no fetch update
        if (instr_in.valid && instr_in.cond) begin
            // Result registered at end of E1
            next_st.res.wr_en = 1'b1;
            if (instr_in.is_branch) begin
                next_st.res.wr_en = 1'b0;
                // Target equals constant shifted plus base
                next_st.pfc_load = 1'b1;
                next_st.program_fetch_counter = packet_base_address_in + br_disp;
            end else if (instr_in.is_immediate16_sum_op) begin
                next_st.res.data = zx(dst_old_in + k16);
            end else begin
                case (instr_in.unit)
                    UNIT_L: begin
                        case (instr_in.op)
                            `OPL_ABS32:     next_st.res.data = sat_abs(src2_in, 1'b0);
                            `OPL_ABS40:     next_st.res.data = sat_abs(src2_in, 1'b1);
                            `OPL_ADD_SS_S:  next_st.res.data = zx(a32 + b32);
                            `OPL_ADD_SS_L:  next_st.res.data = sx(a32) + sx(b32);
                            `OPL_UNSIGNED_SUM_OP_UU_L: next_st.res.data = zx(a32) + zx(b32);
                            `OPL_ADD_SL_L:  next_st.res.data = sx(a32) + src2_in;
                            `OPL_UNSIGNED_SUM_OP_UL_L: next_st.res.data = zx(a32) + src2_in;
                            `OPL_ADD_C5_S:  next_st.res.data = zx(k32 + b32);
                            `OPL_ADD_C5_L:  next_st.res.data = k40 + src2_in;
                            `OPL_AND_RR:    next_st.res.data = zx(a32 & b32);
                            `OPL_AND_C5:    next_st.res.data = zx(k32 & b32);
                            default:        next_st.res.wr_en = 1'b0;
                        endcase
                    end
                    UNIT_S: begin
                        case (instr_in.op[5:0])
                            `OPS_ADD_RR: next_st.res.data = zx(a32 + b32);
                            `OPS_ADD_C5: next_st.res.data = zx(k32 + b32);
                            `OPS_DUAL_HALF_SUM_OP:   next_st.res.data = zx({16'(a32[31:16] + b32[31:16]),
                                                               16'(a32[15:0] + b32[15:0])});
                            `OPS_AND_RR: next_st.res.data = zx(a32 & b32);
                            `OPS_AND_C5: next_st.res.data = zx(k32 & b32);
                            default:     next_st.res.wr_en = 1'b0;
                        endcase
                    end
                    UNIT_D: begin
                        case (instr_in.op[5:0])
                            `OPD_ADD_RR: next_st.res.data = zx(b32 + a32);
                            `OPD_ADD_C5: next_st.res.data = zx(b32 + {27'h0, instr_in.cst5});
                            `OPD_SUM_BYTE_R, `OPD_SUM_HALF_R, `OPD_SUM_WORD_R,
                            `OPD_SUM_BYTE_C, `OPD_SUM_HALF_C, `OPD_SUM_WORD_C:
                                         next_st.res.data = {8'h00, addr_sum};
                            default:     next_st.res.wr_en = 1'b0;
                        endcase
                    end
                    default: next_st.res.wr_en = 1'b0;
                endcase
            end
        end
        // Hold off interrupts through the delay slots, taken or not
        // Five slots counted after the branch executes
        case (st.br_state)
            BR_IDLE: begin
                if (instr_in.valid && instr_in.is_branch) begin
                    next_st.br_state = BR_SLOTS;
                    next_st.slot_cnt = `BRANCH_DELAY_SLOTS;
                end
            end
            BR_SLOTS: begin
                // A new branch in a slot restarts the window
                if (instr_in.valid && instr_in.is_branch) next_st.slot_cnt = `BRANCH_DELAY_SLOTS;
                else if (st.slot_cnt == 3'h1) next_st.br_state = BR_IDLE;
                else next_st.slot_cnt = st.slot_cnt - 3'h1;
            end
            default: next_st.br_state = BR_IDLE;
        endcase
    end

    // Register the whole state on every rising clock edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================
    assign dst_wr_out                = st.res.wr_en;
    assign dst_data_out              = st.res.data;
    assign pfc_load_out              = st.pfc_load;
    assign program_fetch_counter_out = st.program_fetch_counter;
    // Slots are the cycles after the branch cycle
    assign int_block_out             = (st.br_state == BR_SLOTS);
endmodule // alu_unit

// *** alu_unit_checker.sv ***
// Property checker for the add, logic and branch execution unit
`include "alu_unit_defines.svh"
module alu_unit_checker
    import alu_unit_pkg::*;
(
    input wire logic        sys_clk_in,                  // Clock
    input wire logic        rst_in,                      // Reset
    input wire instr_s      instr_in,                    // Instruction
    input wire logic [39:0] src1_in,                     // Source one
    input wire logic [39:0] src2_in,                     // Source two
    input wire logic [31:0] dst_old_in,                  // Old destination
    input wire logic [31:0] packet_base_address_in,      // Packet base
    input wire logic [31:0] addressing_mode_register_in, // Mode settings
    input wire logic        dst_wr_out,                  // Write strobe
    input wire logic [39:0] dst_data_out,                // Result
    input wire logic        pfc_load_out,                // Fetch load
    input wire logic [31:0] program_fetch_counter_out,   // Target
    input wire logic        int_block_out                // Interrupt hold
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // ==========================
    // Decode helpers
    logic go; // Plain op with true predicate
    logic br; // Branch present
    assign go = instr_in.valid && instr_in.cond && !instr_in.is_immediate16_sum_op && !instr_in.is_branch;
    assign br = instr_in.valid && instr_in.is_branch;
    // ==========================
    // Assertions
    abs_sat_a: assert property (
        go && instr_in.unit == UNIT_L && instr_in.op == `OPL_ABS32
        && src2_in[31:0] == 32'h8000_0000
        |=> dst_wr_out && dst_data_out == 40'h00_7FFF_FFFF) else $error("abs saturation wrong");
    and_logic_a: assert property (
        go && instr_in.unit == UNIT_L && instr_in.op == `OPL_AND_RR
        |=> dst_data_out == {8'h00, $past(src1_in[31:0]) & $past(src2_in[31:0])})
        else $error("and wrong");
    dual_half_a: assert property (
        go && instr_in.unit == UNIT_S && instr_in.op[5:0] == `OPS_DUAL_HALF_SUM_OP
        |=> dst_data_out[15:0] == 16'($past(src1_in[15:0]) + $past(src2_in[15:0]))
        && dst_data_out[31:16] == 16'($past(src1_in[31:16]) + $past(src2_in[31:16])))
        else $error("dual_half_sum_op carry");
    immediate16_sum_op_sum_a: assert property (
        instr_in.valid && instr_in.cond && instr_in.is_immediate16_sum_op |=> dst_wr_out
        && dst_data_out[31:0] == 32'($past(dst_old_in) + 32'(signed'($past(instr_in.cst16)))))
        else $error("immediate16_sum_op wrong");
    nop_false_a: assert property (
        instr_in.valid && !instr_in.cond |=> !dst_wr_out && !pfc_load_out)
        else $error("false predicate acted");
    br_target_a: assert property (
        br && instr_in.cond |=> pfc_load_out && program_fetch_counter_out ==
        $past(packet_base_address_in) + 32'(signed'({$past(instr_in.cst21), 2'b00})))
        else $error("branch target wrong");
    slot_hold_a: assert property (
        br |=> int_block_out [*5]) else $error("slot window short");
    slot_end_a: assert property (
        br ##1 (!br) [*5] |=> !int_block_out) else $error("slot window long");
    idle_quiet_a: assert property (
        !instr_in.valid |=> !dst_wr_out && !pfc_load_out) else $error("strobe without request");
    cover property (br ##1 int_block_out);
    cover property (go ##1 dst_wr_out);
    cover property (instr_in.valid && !instr_in.cond);
endmodule // alu_unit_checker
bind alu_unit alu_unit_checker chk (.sys_clk_in, .rst_in, .instr_in, .src1_in, .src2_in,
    .dst_old_in, .packet_base_address_in, .addressing_mode_register_in, .dst_wr_out,
    .dst_data_out, .pfc_load_out, .program_fetch_counter_out, .int_block_out);

// *** dsp_add_logic_branch_unit_test.sv ***
// Self-checking bench for the add, logic and branch execution unit
`include "alu_unit_defines.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, a, e); end end
module dsp_add_logic_branch_unit_test
    import alu_unit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_in = 1'b0;   // Clock
    logic        rst_in = 1'b1;       // Reset
    instr_s      instr_in = '0;       // Instruction
    logic [39:0] src1_in = '0;        // Source one
    logic [39:0] src2_in = '0;        // Source two
    logic [31:0] dst_old_in = '0;     // Old destination
    logic [31:0] packet_base_address_in = '0;      // Packet base
    logic [31:0] addressing_mode_register_in = '0; // Mode settings
    logic [31:0] mode_val = '0;       // Mode for next op
    logic        dst_wr_out, pfc_load_out, int_block_out;
    logic [39:0] dst_data_out;
    logic [31:0] program_fetch_counter_out;
    int          fail_count = 0;      // Mismatches
    int          samples_checked = 0; // Comparisons
    alu_unit dut (.sys_clk_in, .rst_in, .instr_in, .src1_in, .src2_in, .dst_old_in,
        .packet_base_address_in, .addressing_mode_register_in, .dst_wr_out, .dst_data_out,
        .pfc_load_out, .program_fetch_counter_out, .int_block_out);
    // ==========================
    // Clock, 20 ns period
    always #10 sys_clk_in = ~sys_clk_in;
    // Plain instruction with true predicate
    function automatic instr_s mk(unit_sel_e u, logic [6:0] op, logic [4:0] c5, logic [4:0] idx);
        mk = '0;
        mk.valid = 1'b1;
        mk.cond = 1'b1;
        mk.unit = u;
        mk.op = op;
        mk.cst5 = c5;
        mk.src1_idx = idx;
    endfunction
    // One op; a doubles as old destination, answer one cycle on
    task automatic run_op(input instr_s i, input logic [39:0] a, b, e);
        @(posedge sys_clk_in);
        instr_in <= i;
        src1_in <= a;
        src2_in <= b;
        dst_old_in <= a[31:0];
        addressing_mode_register_in <= mode_val;
        @(posedge sys_clk_in);
        instr_in <= '0;
        #1;
        `CHK(dst_wr_out, i.cond) // one cycle
        if (i.cond) `CHK(dst_data_out, e) // result
    endtask
    // ==========================
    // Scenarios
    task automatic t_arith;
        instr_s i;
        run_op(mk(UNIT_L, `OPL_ABS32, 0, 0), 40'h80000000, 40'h80000000, 40'h7FFFFFFF);
        run_op(mk(UNIT_L, `OPL_ABS32, 0, 0), 40'h80004E3D, 40'h80004E3D, 40'h7FFFB1C3);
        run_op(mk(UNIT_L, `OPL_ABS40, 0, 0), 40'h8000000000, 40'h8000000000,
               40'h7FFFFFFFFF);
        run_op(mk(UNIT_L, `OPL_ADD_SS_S, 0, 0), 40'h7FFFFFFF, 40'h1, 40'h80000000);
        run_op(mk(UNIT_L, `OPL_ADD_SS_L, 0, 0), 40'hFFFFFFFF, 40'hFFFFFFFF,
               40'hFFFFFFFFFE);
        run_op(mk(UNIT_L, `OPL_UNSIGNED_SUM_OP_UU_L, 0, 0), 40'hFFFFFFFF, 40'h1, 40'h100000000);
        run_op(mk(UNIT_L, `OPL_ADD_SL_L, 0, 0), 40'hFFFFFFFF, 40'h10, 40'hF);
        run_op(mk(UNIT_L, `OPL_UNSIGNED_SUM_OP_UL_L, 0, 0), 40'hFFFFFFFF, 40'h10, 40'h10000000F);
        run_op(mk(UNIT_S, `OPS_ADD_C5, 5'h10, 0), 40'h0, 40'h20, 40'h10);
        run_op(mk(UNIT_L, `OPL_ADD_C5_S, 5'h1F, 0), 40'h0, 40'hA, 40'h9);
        run_op(mk(UNIT_L, `OPL_ADD_C5_L, 5'h1F, 0), 40'h0, 40'h100000000, 40'hFFFFFFFF);
        run_op(mk(UNIT_S, `OPS_ADD_RR, 0, 0), 40'h5, 40'h7, 40'hC);
        run_op(mk(UNIT_S, `OPS_DUAL_HALF_SUM_OP, 0, 0), 40'h002137E1, 40'h039AE4B8, 40'h03BB1C99);
        run_op(mk(UNIT_L, `OPL_AND_RR, 0, 0), 40'hF7A1302A, 40'h02B6E724, 40'h02A02020);
        run_op(mk(UNIT_S, `OPS_AND_RR, 0, 0), 40'hF7A1302A, 40'h02B6E724, 40'h02A02020);
        run_op(mk(UNIT_L, `OPL_AND_C5, 5'h0F, 0), 40'h32E46936, 40'h32E46936, 40'h6);
        run_op(mk(UNIT_S, `OPS_AND_C5, 5'h10, 0), 40'hFFFFFFFF, 40'hFFFFFFFF,
               40'hFFFFFFF0);
        i = mk(UNIT_S, 0, 0, 0);
        i.is_immediate16_sum_op = 1'b1;
        i.cst16 = 16'h3C29;
        run_op(i, 40'h002137E1, 40'h0, 40'h0021740A);
        i.cst16 = 16'h8000;
        run_op(i, 40'h00010000, 40'h0, 40'h00008000);
        i = mk(UNIT_L, `OPL_ADD_SS_S, 0, 0);
        i.cond = 1'b0;
        run_op(i, 40'h1, 40'h1, 40'h2);
    endtask
    // Address unit, linear then circular
    task automatic t_addr;
        instr_s i;
        run_op(mk(UNIT_D, `OPD_ADD_RR, 0, 4), 40'h1A, 40'h100, 40'h11A);
        run_op(mk(UNIT_D, `OPD_ADD_C5, 5'h1F, 4), 40'h0, 40'h100, 40'h11F);
        run_op(mk(UNIT_D, `OPD_SUM_BYTE_R, 0, 4), 40'h3, 40'h100, 40'h103);
        run_op(mk(UNIT_D, `OPD_SUM_HALF_R, 0, 4), 40'h3, 40'h100, 40'h106);
        run_op(mk(UNIT_D, `OPD_SUM_WORD_R, 0, 4), 40'h3, 40'h100, 40'h10C);
        run_op(mk(UNIT_D, `OPD_SUM_WORD_C, 5'h2, 4), 40'h0, 40'h100, 40'h108);
        run_op(mk(UNIT_D, `OPD_SUM_HALF_C, 5'h3, 4), 40'h0, 40'h100, 40'h106);
        run_op(mk(UNIT_D, `OPD_SUM_BYTE_C, 5'h5, 4), 40'h0, 40'h100, 40'h105);
        mode_val = 32'h0002_0001;
        run_op(mk(UNIT_D, `OPD_SUM_BYTE_R, 0, 4), 40'hB, 40'h100, 40'h103);
        run_op(mk(UNIT_D, `OPD_SUM_HALF_R, 0, 4), 40'hB, 40'h100, 40'h106);
        run_op(mk(UNIT_D, `OPD_SUM_WORD_C, 5'h2, 4), 40'h0, 40'h20000, 40'h20000);
        run_op(mk(UNIT_D, `OPD_SUM_HALF_R, 0, 8), 40'hB, 40'h100, 40'h116);
        mode_val = 32'h0002_0100;
        i = mk(UNIT_D, `OPD_SUM_HALF_R, 0, 4);
        i.side_b = 1'b1;
        run_op(i, 40'hB, 40'h100, 40'h106);
        mode_val = 32'h0040_0002;
        run_op(mk(UNIT_D, `OPD_SUM_HALF_R, 0, 4), 40'hB, 40'h100, 40'h106);
        mode_val = 32'h0;
    endtask
    // Branch target and its delay slot window
    task automatic t_branch(input logic c);
        instr_s i;
        i = '0;
        i.valid = 1'b1;
        i.cond = c;
        i.is_branch = 1'b1;
        i.cst21 = 21'h1FFFFF;
        @(posedge sys_clk_in);
        instr_in <= i;
        packet_base_address_in <= 32'h0000_1000;
        @(posedge sys_clk_in);
        instr_in <= '0;
        #1;
        `CHK(pfc_load_out, c)
        if (c) `CHK(program_fetch_counter_out, 32'h0000_0FFC)
        for (int k = 1; k <= 5; k++) begin
            `CHK(int_block_out, 1'b1)
            @(posedge sys_clk_in);
            #1;
        end
        `CHK(int_block_out, 1'b0)
    endtask
    // ==========================
    // Verdict, single exit point
    task automatic complete_run;
        $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard, about 50000 cycles
    initial begin
        #1000000;
        fail_count++;
        complete_run;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        `CHK(dst_wr_out, 1'b0)
        t_arith;
        t_addr;
        t_branch(1'b1);
        t_branch(1'b0);
        complete_run;
    end
endmodule // dsp_add_logic_branch_unit_test
